// ---- hdl/usc_byte_buf.sv ----
// Byte buffer of one host endpoint with registered read
`timescale 1ns/1ps
`default_nettype none
module usc_byte_buf #(
  parameter int W  = 8,
  parameter int AW = 6
) (
  // Clock
  input  wire logic          sys_clk_in,
  // Write side
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [W-1:0]  wdata_in,
  // Read side
  input  wire logic [AW-1:0] raddr_in,
  output logic      [W-1:0]  rdata_out
);

  logic [W-1:0] mem [2**AW];

  always_ff @(posedge sys_clk_in)
  begin
    if (we_in)
    begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end

endmodule : usc_byte_buf
`default_nettype wire

// ---- hdl/usc_cmd_engine.sv ----
// Command interpreter of the storage bridge, host port to media engine
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Block write takes length 0..64 then that many bytes to out buffer
// - Storage init resets bus, configures storage device, interrupts
// - Init status: detached, fail or overflow, or success
// - Capacity gives 8 bytes: sector count then size, MSB first
// - Readiness check interrupts; success means storage ready
// - Read interrupts per 64-byte chunk; host reads then continues
// - Read ends with one final success or failure interrupt
// - N sectors read give 8N chunk interrupts plus one final
// - Failed read ends early with storage failure status
// - Write interrupts per chunk; host supplies 64 bytes, continues
// - Write ends with final success or failure interrupt
// - N sectors written give 8N request interrupts plus one final
// - Failed write ends early with storage failure status
// - Inquiry data readable by block read after success
// - Error sense interrupts; sense data readable by block read
// - Pin low at reset selects parallel port, else serial
// - Serial mode: pin becomes serial output, host operation only
// - Status codes 14H,15H,16H,17H,1DH,1EH,1FH
// - Block read returns length 0..64 then the data bytes
// - Status fetch returns status and clears interrupt
module usc_cmd_engine
  import usc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  // Host port, deframed bytes
  input  wire logic        host_wr_in,
  input  wire logic        host_rd_in,
  input  wire logic        port_select_in,
  input  wire logic [7:0]  host_wdata_in,
  output logic      [7:0]  host_rdata_out,
  output logic             host_rvalid_out,
  output logic             int_n_out,
  // Interface select pin
  input  wire logic        txd_pin_in,
  input  wire logic        serial_tx_bit_in,
  output logic             txd_out,
  output logic             txd_oe_out,
  output logic             serial_mode_out,
  output logic             host_only_out,
  output logic             mode_valid_out,
  // Media engine
  output logic             media_req_out,
  output logic      [2:0]  media_op_out,
  output logic      [31:0] media_lba_out,
  output logic      [10:0] media_chunk_out,
  input  wire logic        media_done_in,
  input  wire logic [1:0]  media_result_in,
  input  wire logic [63:0] media_cap_in,
  input  wire logic        media_dvalid_in,
  input  wire logic [7:0]  media_data_in,
  input  wire logic [5:0]  media_waddr_in,
  output logic      [7:0]  media_wdata_out
);

  // ==========================================================
  // Reset release and interface strap
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [1:0] txd_s_q;
  logic       mode_valid_q;
  logic       serial_q;

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Unreset so the strap is already settled when reset lifts
  always_ff @(posedge sys_clk_in)
  begin
    txd_s_q <= {txd_s_q[0], txd_pin_in};
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_valid_q <= 1'b0;
      serial_q     <= 1'b0;
    end
    else if (!mode_valid_q)
    begin
      mode_valid_q <= 1'b1;
      serial_q     <= txd_s_q[1];
    end
  end

  // pin driven only after serial selection
  assign txd_oe_out      = mode_valid_q & serial_q;
  assign txd_out         = serial_tx_bit_in;
  assign serial_mode_out = serial_q;
  assign host_only_out   = serial_q;
  assign mode_valid_out  = mode_valid_q;

  // ==========================================================
  // Host strobes
  logic host_cmd_w, host_dwr_w, host_drd_w, host_crd_w;
  // port select splits command and data
  assign host_cmd_w = mode_valid_q & host_wr_in & port_select_in;
  assign host_dwr_w = mode_valid_q & host_wr_in & ~port_select_in;
  assign host_drd_w = mode_valid_q & host_rd_in & ~port_select_in;
  assign host_crd_w = mode_valid_q & host_rd_in & port_select_in;

  // ==========================================================
  // Operation sequencer
  usc_op_t              op_q;
  logic [2:0]           mop_q;
  logic                 dir_wr_q;
  logic [2:0]           pcnt_q;
  logic [31:0]          lba_q;
  logic [7:0]           nsec_q;
  logic [CHUNK_W-1:0]   chunk_q;
  logic [CHUNK_W-1:0]   total_w;
  logic [7:0]           status_q;
  logic                 int_set_q;
  logic                 req_q;
  logic [3:0]           load_cnt_q;
  logic [63:0]          cap_q;
  logic                 load_w;

  assign total_w = CHUNK_W'(nsec_q) << CHUNK_SHIFT;
  assign load_w  = (op_q == OP_BUSY) && (load_cnt_q != 4'h0);

  function automatic logic [7:0] usc_fail_code(input logic [1:0] res,
                                              input logic       xfer);
    if (xfer || res == MRES_FAIL)
      return ST_STORAGE_FAIL;
    else if (res == MRES_ABSENT)
      return ST_DETACHED;
    else
      return ST_BUF_OVER;
  endfunction : usc_fail_code

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_q       <= OP_IDLE;
      mop_q      <= MOP_INIT;
      dir_wr_q   <= 1'b0;
      pcnt_q     <= 3'h0;
      lba_q      <= 32'h0;
      nsec_q     <= 8'h0;
      chunk_q    <= '0;
      status_q   <= 8'h0;
      int_set_q  <= 1'b0;
      req_q      <= 1'b0;
      load_cnt_q <= 4'h0;
      cap_q      <= 64'h0;
    end
    else
    begin
      req_q     <= 1'b0;
      int_set_q <= 1'b0;
      unique case (op_q)
        OP_IDLE:
          if (host_cmd_w)
          begin
            // storage commands go to media engine
            if (host_wdata_in inside {CMD_STORAGE_INIT, CMD_CAPACITY,
                CMD_READINESS, CMD_INQUIRY, CMD_ERROR_SENSE})
            begin
              mop_q <= (host_wdata_in == CMD_STORAGE_INIT) ? MOP_INIT :
                       (host_wdata_in == CMD_CAPACITY)     ? MOP_SIZE :
                       (host_wdata_in == CMD_READINESS)    ? MOP_READY :
                       (host_wdata_in == CMD_INQUIRY)      ? MOP_INQUIRY :
                                                             MOP_SENSE;
              req_q <= 1'b1;
              op_q  <= OP_BUSY;
            end
            else if (host_wdata_in == CMD_SECTOR_READ ||
                     host_wdata_in == CMD_SECTOR_WRITE)
            begin
              dir_wr_q <= (host_wdata_in == CMD_SECTOR_WRITE);
              pcnt_q   <= 3'h0;
              op_q     <= OP_PARAM;
            end
          end
        OP_PARAM:
          if (host_dwr_w)
          begin
            // LBA low byte first, count last
            if (pcnt_q == PARAM_LAST)
            begin
              nsec_q  <= host_wdata_in;
              chunk_q <= '0;
              if (dir_wr_q)
              begin
                status_q  <= ST_WRITE_CHUNK;
                int_set_q <= 1'b1;
                op_q      <= OP_HOLD;
              end
              else
              begin
                mop_q <= MOP_READ;
                req_q <= 1'b1;
                op_q  <= OP_BUSY;
              end
            end
            else
            begin
              lba_q[8*pcnt_q +: 8] <= host_wdata_in;
              pcnt_q               <= pcnt_q + 3'h1;
            end
          end
        OP_BUSY:
          if (load_w)
          begin
            cap_q      <= cap_q << 8;
            load_cnt_q <= load_cnt_q - 4'h1;
            if (load_cnt_q == 4'h1)
            begin
              status_q  <= ST_SUCCESS;
              int_set_q <= 1'b1;
              op_q      <= OP_IDLE;
            end
          end
          else if (media_done_in)
          begin
            if (media_result_in != MRES_OK)
            begin
              // early end of a failed transfer
              status_q  <= usc_fail_code(media_result_in,
                             mop_q == MOP_READ || mop_q == MOP_WRITE);
              int_set_q <= 1'b1;
              op_q      <= OP_IDLE;
            end
            else if (mop_q == MOP_READ)
            begin
              chunk_q   <= chunk_q + 1'b1;
              status_q  <= ST_READ_CHUNK;
              int_set_q <= 1'b1;
              op_q      <= OP_HOLD;
            end
            else if (mop_q == MOP_WRITE)
            begin
              // final status after the last chunk
              chunk_q   <= chunk_q + 1'b1;
              status_q  <= (chunk_q + 1'b1 == total_w) ? ST_SUCCESS :
                                                         ST_WRITE_CHUNK;
              int_set_q <= 1'b1;
              op_q      <= (chunk_q + 1'b1 == total_w) ? OP_IDLE : OP_HOLD;
            end
            else if (mop_q == MOP_SIZE)
            begin
              cap_q      <= media_cap_in;
              load_cnt_q <= CAP_BYTES;
            end
            else
            begin
              // readiness, inquiry, sense and init success
              status_q  <= ST_SUCCESS;
              int_set_q <= 1'b1;
              op_q      <= OP_IDLE;
            end
          end
        OP_HOLD:
          if (host_cmd_w && !dir_wr_q &&
              host_wdata_in == CMD_READ_CONTINUE)
          begin
            // final read status once all chunks are taken
            if (chunk_q == total_w)
            begin
              status_q  <= ST_SUCCESS;
              int_set_q <= 1'b1;
              op_q      <= OP_IDLE;
            end
            else
            begin
              req_q <= 1'b1;
              op_q  <= OP_BUSY;
            end
          end
          else if (host_cmd_w && dir_wr_q &&
                   host_wdata_in == CMD_WRITE_CONT)
          begin
            // chunk supplied, push it to the media
            mop_q <= MOP_WRITE;
            req_q <= 1'b1;
            op_q  <= OP_BUSY;
          end
      endcase
    end
  end

  assign media_req_out   = req_q;
  assign media_op_out    = mop_q;
  assign media_lba_out   = lba_q;
  assign media_chunk_out = chunk_q;

  // ==========================================================
  // Interrupt request
  logic int_pend_q;
  logic stat_rd_w;
  usc_pm_t pm_q;

  assign stat_rd_w = host_drd_w && (pm_q == PM_STAT);

  // clear on status fetch, a new event wins
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      int_pend_q <= 1'b0;
    else if (int_set_q)
      int_pend_q <= 1'b1;
    else if (stat_rd_w)
      int_pend_q <= 1'b0;
  end
  assign int_n_out = ~int_pend_q;

  // ==========================================================
  // Endpoint buffers
  logic [6:0] ibuf_len_q;
  logic [6:0] bw_len_q;
  logic [6:0] idx_q;
  logic [7:0] ibuf_rdata;
  logic       ibuf_we;

  // Overflowing media bytes are dropped, length saturates at 64
  assign ibuf_we = load_w || (media_dvalid_in && ibuf_len_q != LEN_MAX);

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      ibuf_len_q <= 7'h0;
    else if (req_q || (media_done_in && mop_q == MOP_SIZE))
      ibuf_len_q <= 7'h0;
    else if (ibuf_we)
      ibuf_len_q <= ibuf_len_q + 7'h1;
  end

  usc_byte_buf #(.W(8), .AW(BUF_AW)) u_in_buf (
    .sys_clk_in (sys_clk_in),
    .we_in      (ibuf_we),
    .waddr_in   (ibuf_len_q[BUF_AW-1:0]),
    .wdata_in   (load_w ? cap_q[63:56] : media_data_in),
    .raddr_in   (idx_q[BUF_AW-1:0]),
    .rdata_out  (ibuf_rdata)
  );

  usc_byte_buf #(.W(8), .AW(BUF_AW)) u_out_buf (
    .sys_clk_in (sys_clk_in),
    .we_in      (host_dwr_w && pm_q == PM_BWDATA),
    .waddr_in   (idx_q[BUF_AW-1:0]),
    .wdata_in   (host_wdata_in),
    .raddr_in   (media_waddr_in),
    .rdata_out  (media_wdata_out)
  );

  // ==========================================================
  // Host data port modes
  logic [7:0] rdata_q;
  logic       rvalid_q;

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pm_q     <= PM_NONE;
      bw_len_q <= 7'h0;
      idx_q    <= 7'h0;
      rdata_q  <= 8'h0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= host_drd_w | host_crd_w;
      if (host_cmd_w)
      begin
        idx_q <= 7'h0;
        pm_q  <= (host_wdata_in == CMD_BLOCK_WRITE)  ? PM_BWLEN :
                 (host_wdata_in == CMD_BLOCK_READ)   ? PM_BRLEN :
                 (host_wdata_in == CMD_STATUS_FETCH) ? PM_STAT : PM_NONE;
      end
      else if (host_dwr_w && pm_q == PM_BWLEN)
      begin
        // length clamps at 64, zero ends at once
        bw_len_q <= (host_wdata_in > 8'(LEN_MAX)) ? LEN_MAX :
                    host_wdata_in[6:0];
        pm_q     <= (host_wdata_in == 8'h0) ? PM_NONE : PM_BWDATA;
      end
      else if (host_dwr_w && pm_q == PM_BWDATA)
      begin
        idx_q <= idx_q + 7'h1;
        if (idx_q + 7'h1 == bw_len_q)
          pm_q <= PM_NONE;
      end
      if (host_crd_w)
        rdata_q <= {int_n_out, 7'h0};
      else if (host_drd_w)
      begin
        unique case (pm_q)
          PM_STAT:
          begin
            rdata_q <= status_q;
            pm_q    <= PM_NONE;
          end
          // inquiry and sense data via this path
          PM_BRLEN:
          begin
            rdata_q <= {1'b0, ibuf_len_q};
            pm_q    <= (ibuf_len_q == 7'h0) ? PM_NONE : PM_BRDATA;
          end
          PM_BRDATA:
          begin
            rdata_q <= ibuf_rdata;
            idx_q   <= idx_q + 7'h1;
            if (idx_q + 7'h1 == ibuf_len_q)
              pm_q <= PM_NONE;
          end
          default:
            rdata_q <= 8'h0;
        endcase
      end
    end
  end

  assign host_rdata_out  = rdata_q;
  assign host_rvalid_out = rvalid_q;

  // ==========================================================
  // Checks
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  int_clear_a: assert property (stat_rd_w && !int_set_q |=> int_n_out)
    else $error("interrupt not cleared by status fetch");
  stat_value_a: assert property (stat_rd_w |=> host_rdata_out ==
    $past(status_q) && host_rvalid_out)
    else $error("status fetch returned wrong code");
  bw_len_a: assert property (host_dwr_w && pm_q == PM_BWLEN &&
    host_wdata_in != 8'h0 |=> pm_q == PM_BWDATA)
    else $error("block write length not taken");
  read_chunk_a: assert property (op_q == OP_BUSY && !load_w &&
    media_done_in && media_result_in == MRES_OK && mop_q == MOP_READ
    |=> status_q == ST_READ_CHUNK ##1 !int_n_out)
    else $error("no chunk interrupt on read");
  xfer_fail_a: assert property (op_q == OP_BUSY && !load_w &&
    media_done_in && media_result_in == MRES_FAIL
    |=> status_q == ST_STORAGE_FAIL && op_q == OP_IDLE)
    else $error("failure did not end operation");
  read_final_a: assert property (op_q == OP_HOLD && !dir_wr_q &&
    host_cmd_w && host_wdata_in == CMD_READ_CONTINUE &&
    chunk_q == total_w |=> status_q == ST_SUCCESS)
    else $error("final read status missing");
  write_final_a: assert property ($rose(op_q == OP_IDLE) && dir_wr_q &&
    mop_q == MOP_WRITE && status_q == ST_SUCCESS |-> chunk_q == total_w)
    else $error("write finished before all chunks");
  cap_len_a: assert property (load_w && load_cnt_q == 4'h1
    |=> ibuf_len_q == 7'(CAP_BYTES) && status_q == ST_SUCCESS)
    else $error("capacity data length wrong");
  init_detach_a: assert property (op_q == OP_BUSY &&
    mop_q == MOP_INIT && media_done_in && media_result_in == MRES_ABSENT
    |=> status_q == ST_DETACHED)
    else $error("detached status not reported");
  strap_hold_a: assert property (mode_valid_q |=> $stable(serial_q) &&
    txd_oe_out == serial_q)
    else $error("interface selection changed");

  read_op_c: cover property (status_q == ST_READ_CHUNK ##[1:200]
    status_q == ST_SUCCESS);
  write_op_c: cover property (status_q == ST_WRITE_CHUNK ##[1:200]
    status_q == ST_SUCCESS);
  block_rd_c: cover property (pm_q == PM_BRDATA ##1 pm_q == PM_NONE);

endmodule : usc_cmd_engine
`default_nettype wire

// ---- include/usc_pkg.sv ----
// Package of constants and types for the storage command engine
package usc_pkg;

  // ==========================================================
  // Command codes on the command port
  localparam logic [7:0] CMD_BLOCK_READ    = 8'h10;
  localparam logic [7:0] CMD_BLOCK_WRITE   = 8'h11;
  localparam logic [7:0] CMD_STATUS_FETCH  = 8'h12;
  localparam logic [7:0] CMD_STORAGE_INIT  = 8'h13;
  localparam logic [7:0] CMD_CAPACITY      = 8'h14;
  localparam logic [7:0] CMD_READINESS     = 8'h15;
  localparam logic [7:0] CMD_INQUIRY       = 8'h16;
  localparam logic [7:0] CMD_ERROR_SENSE   = 8'h17;
  localparam logic [7:0] CMD_SECTOR_READ   = 8'h18;
  localparam logic [7:0] CMD_READ_CONTINUE = 8'h19;
  localparam logic [7:0] CMD_SECTOR_WRITE  = 8'h1a;
  localparam logic [7:0] CMD_WRITE_CONT    = 8'h1b;

  // ==========================================================
  // Status codes
  localparam logic [7:0] ST_SUCCESS      = 8'h14;
  localparam logic [7:0] ST_ATTACHED     = 8'h15;
  localparam logic [7:0] ST_DETACHED     = 8'h16;
  localparam logic [7:0] ST_BUF_OVER     = 8'h17;
  localparam logic [7:0] ST_READ_CHUNK   = 8'h1d;
  localparam logic [7:0] ST_WRITE_CHUNK  = 8'h1e;
  localparam logic [7:0] ST_STORAGE_FAIL = 8'h1f;

  // ==========================================================
  // Media engine operations and results
  localparam logic [2:0] MOP_INIT    = 3'h0;
  localparam logic [2:0] MOP_SIZE    = 3'h1;
  localparam logic [2:0] MOP_READY   = 3'h2;
  localparam logic [2:0] MOP_INQUIRY = 3'h3;
  localparam logic [2:0] MOP_SENSE   = 3'h4;
  localparam logic [2:0] MOP_READ    = 3'h5;
  localparam logic [2:0] MOP_WRITE   = 3'h6;
  localparam logic [1:0] MRES_OK     = 2'h0;
  localparam logic [1:0] MRES_FAIL   = 2'h1;
  localparam logic [1:0] MRES_ABSENT = 2'h2;
  localparam logic [1:0] MRES_OVER   = 2'h3;

  // ==========================================================
  // Sizes
  localparam int         CHUNK_BYTES = 64;
  localparam int         BUF_AW      = 6;
  localparam int         CHUNK_SHIFT = 3;
  localparam int         CHUNK_W     = 11;
  localparam logic [2:0] PARAM_LAST  = 3'h4;
  localparam logic [3:0] CAP_BYTES   = 4'h8;
  localparam logic [6:0] LEN_MAX     = 7'h40;

  // ==========================================================
  // State types
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_PARAM = 2'b01,
    OP_BUSY  = 2'b11,
    OP_HOLD  = 2'b10
  } usc_op_t;

  typedef enum logic [2:0] {
    PM_NONE   = 3'b000,
    PM_BWLEN  = 3'b001,
    PM_BWDATA = 3'b011,
    PM_BRLEN  = 3'b100,
    PM_BRDATA = 3'b101,
    PM_STAT   = 3'b110
  } usc_pm_t;

endpackage : usc_pkg

// ---- tb/test_usb_storage_cmd_engine.sv ----
// Self-checking bench of the storage command engine
`timescale 1ns/1ps
`default_nettype none
module test_usb_storage_cmd_engine
  import usc_pkg::*;
;
  localparam logic [63:0] CAP_VAL = 64'h0001_e240_0000_0200;
  localparam logic [31:0] LBA     = 32'h1234_5678;
  // ========
  // Signals
  logic        sys_clk_in = 1'b0, reset_n_in = 1'b0, txd_pin_in = 1'b0;
  logic        host_wr_in = 1'b0, host_rd_in = 1'b0, port_select_in = 1'b0;
  logic        serial_tx_bit_in = 1'b1;
  logic [7:0]  host_wdata_in = 8'h00, host_rdata_out, media_wdata_out;
  logic [1:0]  res_cfg = 2'h0, media_result_in;
  logic [10:0] fail_chunk = 11'h7ff, media_chunk_out;
  logic        host_rvalid_out, int_n_out, txd_out, txd_oe_out;
  logic        serial_mode_out, host_only_out, mode_valid_out;
  logic        media_req_out, media_done_in, media_dvalid_in;
  logic [2:0]  media_op_out;
  logic [31:0] media_lba_out;
  logic [63:0] media_cap_in;
  logic [7:0]  media_data_in;
  logic [5:0]  media_waddr_in, wa_q;
  int          error_cnt = 0, n_compared = 0, cycles = 0;

  usc_cmd_engine dut (.sys_clk_in, .reset_n_in, .host_wr_in, .host_rd_in,
    .port_select_in, .host_wdata_in, .host_rdata_out, .host_rvalid_out,
    .int_n_out, .txd_pin_in, .serial_tx_bit_in, .txd_out, .txd_oe_out,
    .serial_mode_out, .host_only_out, .mode_valid_out, .media_req_out,
    .media_op_out, .media_lba_out, .media_chunk_out, .media_done_in,
    .media_result_in, .media_cap_in, .media_dvalid_in, .media_data_in,
    .media_waddr_in, .media_wdata_out);
  usc_media_model #(.CAP_VAL(CAP_VAL)) mdl (.sys_clk_in(sys_clk_in),
    .req_in(media_req_out), .op_in(media_op_out),
    .chunk_in(media_chunk_out), .res_cfg_in(res_cfg),
    .fail_chunk_in(fail_chunk), .done_out(media_done_in),
    .result_out(media_result_in), .cap_out(media_cap_in),
    .dvalid_out(media_dvalid_in), .data_out(media_data_in),
    .waddr_out(media_waddr_in));

  always #2 sys_clk_in = ~sys_clk_in;
  // Hang guard, well above the longest run
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      error_cnt++;
      results();
    end
  end
  // out buffer bytes reach the media in address order
  always @(posedge sys_clk_in)
  begin
    wa_q <= media_waddr_in;
    if (media_op_out == MOP_WRITE && mode_valid_out === 1'b1)
      chk8(media_wdata_out, {2'h0, wa_q});
  end
  // ========
  // Shared tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic wr(input logic ps, input logic [7:0] d);
    host_wr_in     <= 1'b1;
    port_select_in <= ps;
    host_wdata_in  <= d;
    @(posedge sys_clk_in);
    host_wr_in    <= 1'b0;
    host_wdata_in <= ~d;
    @(posedge sys_clk_in);
  endtask : wr
  task automatic rd(output logic [7:0] d);
    host_rd_in     <= 1'b1;
    port_select_in <= 1'b0;
    @(posedge sys_clk_in);
    host_rd_in <= 1'b0;
    @(posedge sys_clk_in);
    d = host_rdata_out;
    chk8({7'h0, host_rvalid_out}, 8'h01);
  endtask : rd
  task automatic wait_int();
    int i;
    for (i = 0; i < 3000 && int_n_out !== 1'b0; i++)
      @(posedge sys_clk_in);
    chk8({7'h0, int_n_out}, 8'h00);
  endtask : wait_int
  task automatic fetch(input logic [7:0] exp);
    logic [7:0] s;
    wr(1'b1, CMD_STATUS_FETCH);
    rd(s);
    chk8(s, exp);
    chk8({7'h0, int_n_out}, 8'h01);
  endtask : fetch
  task automatic cmd_done(input logic [7:0] c, input logic [7:0] st);
    wr(1'b1, c);
    wait_int();
    fetch(st);
  endtask : cmd_done
  task automatic blk_len(input logic [7:0] exp);
    logic [7:0] s;
    wr(1'b1, CMD_BLOCK_READ);
    rd(s);
    chk8(s, exp);
  endtask : blk_len
  task automatic do_reset();
    int i;
    reset_n_in <= 1'b0;
    repeat (12) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    for (i = 0; i < 10 && mode_valid_out !== 1'b1; i++)
      @(posedge sys_clk_in);
    @(posedge sys_clk_in);
  endtask : do_reset
  // ========
  // Scenarios
  task automatic t_init();
    logic [7:0] st [4] = '{ST_SUCCESS, ST_STORAGE_FAIL, ST_DETACHED,
                           ST_BUF_OVER};
    for (int i = 0; i < 4; i++)
    begin
      res_cfg <= 2'(i);
      cmd_done(CMD_STORAGE_INIT, st[i]);
    end
    res_cfg <= MRES_OK;
  endtask : t_init
  task automatic t_cap();
    logic [7:0] s;
    cmd_done(CMD_CAPACITY, ST_SUCCESS);
    blk_len(8'h08);
    for (int i = 7; i >= 0; i--)
    begin
      rd(s);
      chk8(s, CAP_VAL[i*8 +: 8]);
    end
  endtask : t_cap
  task automatic t_query();
    cmd_done(CMD_READINESS, ST_SUCCESS);
    cmd_done(CMD_INQUIRY, ST_SUCCESS);
    blk_len(8'h24);
    cmd_done(CMD_ERROR_SENSE, ST_SUCCESS);
    blk_len(8'h40);
  endtask : t_query
  task automatic t_xfer(input logic w, input int ns, input int fc);
    logic [7:0] s;
    fail_chunk <= 11'(fc);
    res_cfg    <= MRES_FAIL;
    wr(1'b1, w ? CMD_SECTOR_WRITE : CMD_SECTOR_READ);
    // address low byte first, then count
    for (int i = 0; i < 4; i++) wr(1'b0, LBA[i*8 +: 8]);
    wr(1'b0, 8'(ns));
    for (int c = 0; c < 8 * ns; c++)
    begin
      wait_int();
      if (c == fc + int'(w))
      begin
        fetch(ST_STORAGE_FAIL);
        return;
      end
      fetch(w ? ST_WRITE_CHUNK : ST_READ_CHUNK);
      if (c == 1)
        for (int i = 0; i < 4; i++)
          chk8(media_lba_out[i*8 +: 8], LBA[i*8 +: 8]);
      if (w)
      begin
        wr(1'b1, CMD_BLOCK_WRITE);
        wr(1'b0, 8'h40);
        for (int j = 0; j < 64; j++) wr(1'b0, 8'(j));
        wr(1'b1, CMD_WRITE_CONT);
      end
      else
      begin
        blk_len(8'h40);
        for (int j = 0; j < 64; j++)
        begin
          rd(s);
          chk8(s, 8'(j) ^ 8'(c));
        end
        wr(1'b1, CMD_READ_CONTINUE);
      end
    end
    wait_int();
    fetch(ST_SUCCESS);
  endtask : t_xfer
  task automatic t_serial();
    txd_pin_in <= 1'b1;
    do_reset();
    chk8({5'h0, serial_mode_out, host_only_out, txd_oe_out}, 8'h07);
    for (int i = 0; i < 2; i++)
    begin
      serial_tx_bit_in <= i[0];
      @(posedge sys_clk_in);
      #1;
      chk8({7'h0, txd_out}, {7'h0, i[0]});
    end
  endtask : t_serial
  // ========
  // Main sequence and verdict
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial
  begin
    do_reset();
    chk8({5'h0, serial_mode_out, host_only_out, txd_oe_out}, 8'h00);
    t_init();
    t_cap();
    t_query();
    t_xfer(1'b0, 2, 255);
    t_xfer(1'b0, 1, 3);
    t_xfer(1'b1, 1, 2);
    t_xfer(1'b1, 1, 255);
    t_serial();
    results();
  end
endmodule : test_usb_storage_cmd_engine
`default_nettype wire

// ---- tb/usc_media_model.sv ----
// Behavioural media engine on the far side of the command engine
`timescale 1ns/1ps
`default_nettype none
module usc_media_model
  import usc_pkg::*;
#(
  parameter logic [63:0] CAP_VAL = 64'h0000_1000_0000_0200
) (
  // Requests
  input  wire logic        sys_clk_in,
  input  wire logic        req_in,
  input  wire logic [2:0]  op_in,
  input  wire logic [10:0] chunk_in,
  // Scenario controls
  input  wire logic [1:0]  res_cfg_in,
  input  wire logic [10:0] fail_chunk_in,
  // Answers
  output logic             done_out,
  output logic      [1:0]  result_out,
  output logic      [63:0] cap_out,
  output logic             dvalid_out,
  output logic      [7:0]  data_out,
  output logic      [5:0]  waddr_out
);
  int n;
  int k;
  initial
  begin
    done_out   = 1'b0;
    result_out = 2'h0;
    cap_out    = 64'h0;
    dvalid_out = 1'b0;
    data_out   = 8'h00;
    waddr_out  = 6'h00;
  end
  // ========
  // One request at a time
  always
  begin
    @(posedge sys_clk_in);
    if (req_in === 1'b1)
    begin
      // Odd chunks answer slowly
      repeat (chunk_in[0] ? 30 : 2) @(posedge sys_clk_in);
      n = (op_in == MOP_INQUIRY) ? 36 : (op_in >= MOP_SENSE) ? 64 : 0;
      for (k = 0; k < n; k++)
      begin
        dvalid_out <= (op_in != MOP_WRITE);
        data_out   <= 8'(k) ^ chunk_in[7:0];
        waddr_out  <= 6'(k);
        @(posedge sys_clk_in);
      end
      // Released bus shows the inverse, never a stale byte
      dvalid_out <= 1'b0;
      data_out   <= ~data_out;
      result_out <= (op_in < MOP_READ || chunk_in == fail_chunk_in) ?
                    res_cfg_in : MRES_OK;
      cap_out    <= CAP_VAL;
      done_out   <= 1'b1;
      @(posedge sys_clk_in);
      done_out   <= 1'b0;
      result_out <= ~result_out;
      cap_out    <= ~CAP_VAL;
    end
  end
endmodule : usc_media_model
`default_nettype wire
